// ===== core/ssc_pkg.sv
package ssc_pkg;

   // ------------------------------------------------------------
   // Clock and serial timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned BAUD_9600 = 9600;
   localparam int unsigned BAUD_19200 = 19200;
   localparam int unsigned BAUD_115200 = 115200;
   localparam int unsigned DIV_9600 = CLK_HZ / (OVERSAMPLE * BAUD_9600);
   localparam int unsigned DIV_19200 = CLK_HZ / (OVERSAMPLE * BAUD_19200);
   localparam int unsigned DIV_115200 = CLK_HZ / (OVERSAMPLE * BAUD_115200);
   localparam int unsigned DIV_W = 12;
   localparam int unsigned SETTLE_CYCLES = 16;

   // ------------------------------------------------------------
   // Switch banks
   // ------------------------------------------------------------
   localparam int unsigned RATE_SW_W = 4;
   localparam int unsigned ADDR_W = 8;
   localparam logic [3:0] RATE_SW_FACTORY = 4'h4;
   localparam logic [7:0] ADDR_SW_FACTORY = 8'h01;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [7:0] ADDR_BROADCAST = 8'h00;

   // Switch codes, bit 0 is switch 1
   localparam logic [3:0] RC_9600_NONE = 4'h0;
   localparam logic [3:0] RC_9600_EVEN = 4'h1;
   localparam logic [3:0] RC_9600_ODD = 4'h2;
   localparam logic [3:0] RC_19200_NONE = 4'h3;
   localparam logic [3:0] RC_19200_EVEN = 4'h4;
   localparam logic [3:0] RC_19200_ODD = 4'h5;
   localparam logic [3:0] RC_115200_NONE = 4'h6;
   localparam logic [3:0] RC_115200_EVEN = 4'h7;
   localparam logic [3:0] RC_115200_ODD = 4'h8;

   // Decoded selections
   localparam logic [1:0] BAUD_SEL_9600 = 2'h0;
   localparam logic [1:0] BAUD_SEL_19200 = 2'h1;
   localparam logic [1:0] BAUD_SEL_115200 = 2'h2;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;

   // ------------------------------------------------------------
   // Holding registers
   // ------------------------------------------------------------
   localparam int unsigned REG_W = 16;
   localparam logic [15:0] IDX_SWITCH_RATE_SETTING = 16'h0006;
   localparam logic [15:0] IDX_SWITCH_NODE_ADDRESS = 16'h0007;

   typedef enum logic [1:0] {
      SSC_ST_WAIT_CFG,
      SSC_ST_IDLE,
      SSC_ST_REPLY
   } ssc_state_t;

endpackage

// ===== core/ssc_switch_capture.sv
module ssc_switch_capture
   import ssc_pkg::*;
#(
   parameter int unsigned SETTLE = SETTLE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ssc_pkg::RATE_SW_W-1:0] rate_sw,
   input wire logic [ssc_pkg::ADDR_W-1:0] addr_sw,
   output logic done,
   output logic [ssc_pkg::RATE_SW_W-1:0] rate_code,
   output logic [1:0] baud_sel,
   output logic [1:0] parity_sel,
   output logic [ssc_pkg::ADDR_W-1:0] node_addr
);
   import ssc_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [11:0] s1_ff;
   logic [11:0] s2_ff;
   logic [11:0] s3_ff;
   logic [7:0] settle_ff;
   logic done_ff;
   logic [3:0] rate_ff;
   logic [1:0] baud_ff;
   logic [1:0] par_ff;
   logic [7:0] addr_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= 12'h000;
         s2_ff <= 12'h000;
         s3_ff <= 12'h000;
      end else begin
         s1_ff <= {addr_sw, rate_sw};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire stable = (s2_ff == s3_ff);
   wire settled = (settle_ff == SETTLE[7:0]);
   wire take = stable && settled && !done_ff;
   wire [3:0] sw_rate = s3_ff[3:0];
   wire [7:0] sw_addr = s3_ff[11:4];
   logic [1:0] dec_baud;
   logic [1:0] dec_par;

   always_comb begin
      dec_baud = BAUD_SEL_19200;
      dec_par = PAR_EVEN;
      case (sw_rate) // RL1
         RC_9600_NONE: begin dec_baud = BAUD_SEL_9600; dec_par = PAR_NONE; end
         RC_9600_EVEN: begin dec_baud = BAUD_SEL_9600; dec_par = PAR_EVEN; end
         RC_9600_ODD: begin dec_baud = BAUD_SEL_9600; dec_par = PAR_ODD; end
         RC_19200_NONE: begin dec_baud = BAUD_SEL_19200; dec_par = PAR_NONE; end
         RC_19200_EVEN: begin dec_baud = BAUD_SEL_19200; dec_par = PAR_EVEN; end
         RC_19200_ODD: begin dec_baud = BAUD_SEL_19200; dec_par = PAR_ODD; end
         RC_115200_NONE: begin dec_baud = BAUD_SEL_115200; dec_par = PAR_NONE; end
         RC_115200_EVEN: begin dec_baud = BAUD_SEL_115200; dec_par = PAR_EVEN; end
         RC_115200_ODD: begin dec_baud = BAUD_SEL_115200; dec_par = PAR_ODD; end
         // Undefined codes fall back to the factory setting
         default: begin dec_baud = BAUD_SEL_19200; dec_par = PAR_EVEN; end
      endcase
   end

   // Switch 1 is the LSB already, so the bank is the binary address
   wire [7:0] clamp_addr = (sw_addr == ADDR_BROADCAST) ? ADDR_MIN : // RL4
                           (sw_addr > ADDR_MAX) ? ADDR_MAX : sw_addr; // RL2 RL3 RL5 RL6

   // ------------------------------------------------------------
   // One-shot capture after reset
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         settle_ff <= 8'h00;
         done_ff <= 1'b0;
         rate_ff <= RATE_SW_FACTORY;
         baud_ff <= BAUD_SEL_19200;
         par_ff <= PAR_EVEN;
         addr_ff <= ADDR_SW_FACTORY;
      end else begin
         if (!settled) begin
            settle_ff <= settle_ff + 8'h01;
         end
         // Frozen afterwards: switches moved at run time are ignored
         if (take) begin // RL17
            done_ff <= 1'b1;
            rate_ff <= sw_rate;
            baud_ff <= dec_baud;
            par_ff <= dec_par;
            addr_ff <= clamp_addr;
         end
      end
   end

   assign done = done_ff;
   assign rate_code = rate_ff;
   assign baud_sel = baud_ff;
   assign parity_sel = par_ff;
   assign node_addr = addr_ff;
endmodule

// ===== core/ssc_switch_config.sv
// Summary of operation
// RL1: The four rate switches select 9600, 19200 or 115200 baud with none, even or odd parity, factory 19200 even.
// RL2: The address bank forms an eight-bit binary node address, switch 1 least and switch 8 most significant.
// RL3: The effective node address always lies between 1 and 247.
// RL4: A switch address of zero becomes effective address 1.
// RL5: A switch address above 247 becomes effective address 247.
// RL6: Addresses 248 to 255 are never used as an effective address and the master must not target them.
// RL7: Requests to address 0 are neither executed nor answered.
// RL8: The master sends only writes to address 0 and waits for no answer.
// RL9: The device transmits only in answer to a master request.
// RL10: The device never addresses other slaves; its replies go to the master only.
// RL11: The master keeps at most one transaction outstanding.
// RL12: A request to the own address is executed and answered by exactly one reply.
// RL13: Holding register 0x06 reads back the rate and parity switch setting.
// RL14: Holding register 0x07 reads back the effective node address.
// RL15: Each reply leads with the own effective node address.
// RL16: Without parity a second stop bit keeps the character at eleven bits.
// RL17: Both switch banks are sampled once after reset and then held.
module ssc_switch_config
   import ssc_pkg::*;
#(
   parameter int unsigned SETTLE = SETTLE_CYCLES
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [ssc_pkg::RATE_SW_W-1:0] RATE_SW,
   input wire logic [ssc_pkg::ADDR_W-1:0] ADDR_SW,
   input wire logic RX_FRAME_VALID,
   input wire logic [ssc_pkg::ADDR_W-1:0] RX_FRAME_ADDR,
   input wire logic TX_DONE,
   input wire logic REG_RD,
   input wire logic [15:0] REG_IDX,
   output logic CFG_VALID,
   output logic [1:0] BAUD_SEL,
   output logic [1:0] PARITY_SEL,
   output logic TWO_STOP,
   output logic BAUD_TICK,
   output logic [ssc_pkg::ADDR_W-1:0] NODE_ADDR,
   output logic REQ_EXECUTE,
   output logic TX_GRANT,
   output logic [ssc_pkg::ADDR_W-1:0] REPLY_ADDR,
   output logic REG_RD_ACK,
   output logic REG_RD_HIT,
   output logic [ssc_pkg::REG_W-1:0] REG_RD_DATA
);
   import ssc_pkg::*;

   // ------------------------------------------------------------
   // Switch capture
   // ------------------------------------------------------------
   logic cap_done;
   logic [3:0] cap_rate;
   logic [1:0] cap_baud;
   logic [1:0] cap_par;
   logic [7:0] cap_addr;

   ssc_switch_capture #(
      .SETTLE(SETTLE)
   ) u_capture (
      .clk(CLK),
      .rst(SYS_RST),
      .rate_sw(RATE_SW),
      .addr_sw(ADDR_SW),
      .done(cap_done),
      .rate_code(cap_rate),
      .baud_sel(cap_baud),
      .parity_sel(cap_par),
      .node_addr(cap_addr)
   );

   // ------------------------------------------------------------
   // Oversample tick
   // ------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt_ff;
   logic tick_ff;
   logic two_stop_ff;

   wire [DIV_W-1:0] div_last = (cap_baud == BAUD_SEL_9600) ? DIV_W'(DIV_9600 - 1) :
                               (cap_baud == BAUD_SEL_115200) ? DIV_W'(DIV_115200 - 1) :
                               DIV_W'(DIV_19200 - 1);
   wire div_wrap = (div_cnt_ff >= div_last);

   // Divider held at zero until the rate is captured
   wire [DIV_W-1:0] nxt_div_cnt = (div_wrap || !cap_done) ? '0 : div_cnt_ff + DIV_W'(1);
   wire nxt_tick = div_wrap && cap_done;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= nxt_tick;
      end
   end

   // ------------------------------------------------------------
   // Character format
   // ------------------------------------------------------------
   // No parity keeps eleven bits per character by a second stop bit
   wire nxt_two_stop = (cap_par == PAR_NONE); // RL16

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         two_stop_ff <= 1'b0;
      end else begin
         two_stop_ff <= nxt_two_stop;
      end
   end

   // ------------------------------------------------------------
   // Request filter
   // ------------------------------------------------------------
   ssc_state_t state_ff;
   ssc_state_t nxt_state;
   logic exec_ff;
   logic grant_ff;
   logic [7:0] reply_addr_ff;

   // Broadcast and foreign addresses never match, clamped address is never 0
   wire frame_bcast = (RX_FRAME_ADDR == ADDR_BROADCAST); // RL7
   wire frame_reserved = (RX_FRAME_ADDR > ADDR_MAX); // RL6
   wire frame_mine = (RX_FRAME_ADDR == cap_addr) && !frame_bcast && !frame_reserved; // RL12
   wire own_frame = RX_FRAME_VALID && frame_mine; // RL7 RL12
   wire accept = (state_ff == SSC_ST_IDLE) && own_frame; // RL11
   wire reply_owed = (nxt_state == SSC_ST_REPLY);

   // ------------------------------------------------------------
   // Transaction state
   // ------------------------------------------------------------

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SSC_ST_WAIT_CFG: begin
            if (cap_done) begin
               nxt_state = SSC_ST_IDLE;
            end
         end
         SSC_ST_IDLE: begin
            if (accept) begin
               nxt_state = SSC_ST_REPLY;
            end
         end
         SSC_ST_REPLY: begin
            if (TX_DONE) begin
               nxt_state = SSC_ST_IDLE;
            end
         end
         default: nxt_state = SSC_ST_WAIT_CFG;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_ff <= SSC_ST_WAIT_CFG;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Reply permission
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         exec_ff <= 1'b0;
      end else begin
         exec_ff <= accept; // RL12
      end
   end

   // Transmit only while a reply is owed, one reply per request
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         grant_ff <= 1'b0;
      end else begin
         grant_ff <= reply_owed; // RL9 RL12
      end
   end

   // Replies carry the own address only, never another slave's
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         reply_addr_ff <= ADDR_SW_FACTORY;
      end else begin
         reply_addr_ff <= cap_addr; // RL10 RL15
      end
   end

   // ------------------------------------------------------------
   // Holding register read port
   // ------------------------------------------------------------
   logic ack_ff;
   logic hit_ff;
   logic [REG_W-1:0] data_ff;

   // One entry per read-only holding register
   localparam int unsigned NUM_HOLD = 2;
   wire [REG_W-1:0] hold_idx [NUM_HOLD];
   wire [REG_W-1:0] hold_val [NUM_HOLD];
   wire [REG_W-1:0] hold_data [NUM_HOLD];
   wire [NUM_HOLD-1:0] hold_sel;

   assign hold_idx[0] = IDX_SWITCH_RATE_SETTING;
   assign hold_val[0] = {12'h000, cap_rate}; // RL13
   assign hold_idx[1] = IDX_SWITCH_NODE_ADDRESS;
   assign hold_val[1] = {8'h00, cap_addr}; // RL14

   // Indices are distinct, so at most one entry drives data
   for (genvar g = 0; g < NUM_HOLD; g++) begin : g_hold
      assign hold_sel[g] = (REG_IDX == hold_idx[g]);
      assign hold_data[g] = hold_sel[g] ? hold_val[g] : '0;
   end

   wire idx_known = |hold_sel;
   wire [REG_W-1:0] rd_mux = hold_data[0] | hold_data[1];
   wire [REG_W-1:0] nxt_data = REG_RD ? rd_mux : '0;

   // ------------------------------------------------------------
   // Read response
   // ------------------------------------------------------------
   // Writes have no port here: both registers are read-only
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= REG_RD;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         hit_ff <= 1'b0;
      end else begin
         hit_ff <= REG_RD && idx_known;
      end
   end

   // Data is zero outside an answer so stale values never linger
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         data_ff <= '0;
      end else begin
         data_ff <= nxt_data;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic cfg_ff;
   logic [1:0] baud_o_ff;
   logic [1:0] par_o_ff;
   logic [7:0] node_o_ff;

   // All follow the capture by one cycle, so they change on one edge
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cfg_ff <= 1'b0;
      end else begin
         cfg_ff <= cap_done;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         baud_o_ff <= BAUD_SEL_19200;
      end else begin
         baud_o_ff <= cap_baud;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         par_o_ff <= PAR_EVEN;
      end else begin
         par_o_ff <= cap_par;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         node_o_ff <= ADDR_SW_FACTORY;
      end else begin
         node_o_ff <= cap_addr;
      end
   end

   assign CFG_VALID = cfg_ff;
   assign BAUD_SEL = baud_o_ff;
   assign PARITY_SEL = par_o_ff;
   assign TWO_STOP = two_stop_ff;
   assign BAUD_TICK = tick_ff;
   assign NODE_ADDR = node_o_ff;
   assign REQ_EXECUTE = exec_ff;
   assign TX_GRANT = grant_ff;
   assign REPLY_ADDR = reply_addr_ff;
   assign REG_RD_ACK = ack_ff;
   assign REG_RD_HIT = hit_ff;
   assign REG_RD_DATA = data_ff;
endmodule

// ===== bench/ssc_switch_config_props.sv
module ssc_switch_config_props
   import ssc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic RX_FRAME_VALID,
   input wire logic [ssc_pkg::ADDR_W-1:0] RX_FRAME_ADDR,
   input wire logic TX_DONE,
   input wire logic REG_RD,
   input wire logic [15:0] REG_IDX,
   input wire logic CFG_VALID,
   input wire logic [1:0] PARITY_SEL,
   input wire logic TWO_STOP,
   input wire logic [ssc_pkg::ADDR_W-1:0] NODE_ADDR,
   input wire logic REQ_EXECUTE,
   input wire logic TX_GRANT,
   input wire logic [ssc_pkg::ADDR_W-1:0] REPLY_ADDR,
   input wire logic REG_RD_ACK,
   input wire logic REG_RD_HIT,
   input wire logic [ssc_pkg::REG_W-1:0] REG_RD_DATA
);
   // ------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire logic idx_hit = REG_IDX == IDX_SWITCH_RATE_SETTING || REG_IDX == IDX_SWITCH_NODE_ADDRESS;

   a_rd_answer: assert property (REG_RD |=> REG_RD_ACK && REG_RD_HIT == $past(idx_hit))
      else $error("read answer wrong");
   a_rd_node: assert property (REG_RD && REG_IDX == IDX_SWITCH_NODE_ADDRESS |=> REG_RD_DATA == {8'h00, NODE_ADDR})
      else $error("node address read wrong");
   a_rd_miss: assert property (REG_RD && !idx_hit |=> REG_RD_DATA == 16'h0000)
      else $error("unmapped read gave data");
   a_addr_range: assert property (CFG_VALID |-> NODE_ADDR >= ADDR_MIN && NODE_ADDR <= ADDR_MAX)
      else $error("node address out of range");
   a_cfg_held: assert property (CFG_VALID |=> $stable(NODE_ADDR) && $stable(PARITY_SEL))
      else $error("captured setting changed");
   a_two_stop: assert property (TWO_STOP == (PARITY_SEL == PAR_NONE))
      else $error("stop bits wrong");
   a_exec_cause: assert property (REQ_EXECUTE |-> $past(RX_FRAME_VALID) && $past(RX_FRAME_ADDR) == NODE_ADDR)
      else $error("execute without own request");
   a_no_bcast: assert property (RX_FRAME_VALID && RX_FRAME_ADDR == ADDR_BROADCAST |=> !REQ_EXECUTE)
      else $error("broadcast executed");
   a_grant_cause: assert property ($rose(TX_GRANT) |-> REQ_EXECUTE)
      else $error("unsolicited grant");
   a_grant_hold: assert property (TX_GRANT && !TX_DONE |=> TX_GRANT && !REQ_EXECUTE)
      else $error("grant dropped early");
   a_grant_end: assert property (TX_GRANT && TX_DONE |=> !TX_GRANT)
      else $error("grant kept after reply");
   a_reply_addr: assert property (TX_GRANT |-> REPLY_ADDR == NODE_ADDR)
      else $error("reply address wrong");
   c_exec: cover property (REQ_EXECUTE);
   c_bcast: cover property (RX_FRAME_VALID && RX_FRAME_ADDR == ADDR_BROADCAST);
   c_miss: cover property (REG_RD_ACK && !REG_RD_HIT);
endmodule

bind ssc_switch_config ssc_switch_config_props u_props (
   .CLK(CLK), .SYS_RST(SYS_RST), .RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME_ADDR(RX_FRAME_ADDR),
   .TX_DONE(TX_DONE), .REG_RD(REG_RD), .REG_IDX(REG_IDX), .CFG_VALID(CFG_VALID), .PARITY_SEL(PARITY_SEL),
   .TWO_STOP(TWO_STOP), .NODE_ADDR(NODE_ADDR), .REQ_EXECUTE(REQ_EXECUTE), .TX_GRANT(TX_GRANT),
   .REPLY_ADDR(REPLY_ADDR), .REG_RD_ACK(REG_RD_ACK), .REG_RD_HIT(REG_RD_HIT), .REG_RD_DATA(REG_RD_DATA)
);

// ===== bench/ssc_master_model.sv
module ssc_master_model
   import ssc_pkg::*;
(
   input wire logic clk,
   input wire logic tx_grant,
   output logic frame_valid,
   output logic [ssc_pkg::ADDR_W-1:0] frame_addr,
   output logic tx_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Single master, one transaction at a time
   // ------------------------------------------------------------
   initial begin
      frame_valid = 1'b0;
      frame_addr = 8'h5a;
      tx_done = 1'b0;
   end

   task automatic request(input logic [7:0] addr, input int delay, output bit granted);
      granted = 1'b0;
      if (addr > ADDR_MAX) return;
      @(posedge clk);
      frame_valid <= 1'b1;
      frame_addr <= addr;
      @(posedge clk);
      frame_valid <= 1'b0;
      // Released byte lane must not look like a held address
      frame_addr <= ~addr;
      if (addr == ADDR_BROADCAST) return;
      repeat (4) begin
         if (!granted) begin
            @(posedge clk);
            #1;
            granted = tx_grant === 1'b1;
         end
      end
      if (!granted) return;
      repeat (delay) @(posedge clk);
      @(posedge clk);
      tx_done <= 1'b1;
      // Next request only after the reply is complete
      @(posedge clk);
      tx_done <= 1'b0;
   endtask
endmodule

// ===== bench/ssc_switch_config_tb_top.sv
module ssc_switch_config_tb_top
   import ssc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] rate_sw = RATE_SW_FACTORY;
   logic [7:0] addr_sw = ADDR_SW_FACTORY;
   logic reg_rd = 1'b0;
   logic [15:0] reg_idx = 16'h0000;
   logic frame_valid, tx_done, cfg_valid, two_stop, baud_tick, req_execute, tx_grant, rd_ack, rd_hit;
   logic [7:0] frame_addr, node_addr, reply_addr;
   logic [1:0] baud_sel, parity_sel;
   logic [15:0] rd_data;
   logic [7:0] sw_tab [9] = '{8'h00, 8'h01, 8'h19, 8'h37, 8'hf7, 8'hf8, 8'hff, 8'h80, 8'h02};
   logic [7:0] exp_tab [9] = '{8'h01, 8'h01, 8'h19, 8'h37, 8'hf7, 8'hf7, 8'hf7, 8'h80, 8'h02};
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int execs = 0;
   int n, e0;
   bit granted;

   always #5 clk = ~clk;

   ssc_switch_config #(.SETTLE(4)) u_ssc_switch_config (
      .CLK(clk), .SYS_RST(sys_rst), .RATE_SW(rate_sw), .ADDR_SW(addr_sw), .RX_FRAME_VALID(frame_valid),
      .RX_FRAME_ADDR(frame_addr), .TX_DONE(tx_done), .REG_RD(reg_rd), .REG_IDX(reg_idx), .CFG_VALID(cfg_valid),
      .BAUD_SEL(baud_sel), .PARITY_SEL(parity_sel), .TWO_STOP(two_stop), .BAUD_TICK(baud_tick),
      .NODE_ADDR(node_addr), .REQ_EXECUTE(req_execute), .TX_GRANT(tx_grant), .REPLY_ADDR(reply_addr),
      .REG_RD_ACK(rd_ack), .REG_RD_HIT(rd_hit), .REG_RD_DATA(rd_data)
   );

   ssc_master_model u_ssc_master_model (
      .clk(clk), .tx_grant(tx_grant), .frame_valid(frame_valid), .frame_addr(frame_addr), .tx_done(tx_done)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [15:0] idx, input logic hit, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_idx <= idx;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check({14'h0, rd_ack, rd_hit}, {14'h0, 1'b1, hit});
      check(rd_data, exp);
   endtask

   // Bounded run; also counts execute pulses
   always @(posedge clk) begin
      cycles++;
      execs += int'(req_execute === 1'b1);
      if (cycles == 40000) begin
         mismatches++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // One power-up per rate code, each with its own address setting
   // ------------------------------------------------------------
   initial begin
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         sys_rst <= 1'b1;
         rate_sw <= i[3:0];
         addr_sw <= sw_tab[i];
         repeat (2) @(posedge clk);
         sys_rst <= 1'b0;
         n = 0;
         while (cfg_valid !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
         end
         // Moving switches after capture must change nothing
         rate_sw <= ~i[3:0];
         addr_sw <= ~sw_tab[i];
         rd(IDX_SWITCH_RATE_SETTING, 1'b1, {12'h000, i[3:0]});
         rd(IDX_SWITCH_NODE_ADDRESS, 1'b1, {8'h00, exp_tab[i]});
         rd(16'h0008, 1'b0, 16'h0000);
         check({3'h0, baud_sel, parity_sel, two_stop, node_addr},
               {3'h0, 2'(i / 3), 2'(i % 3), i % 3 == 0, exp_tab[i]});
         n = 0;
         while (baud_tick !== 1'b1 && n < 800) begin
            @(posedge clk);
            #1;
            n++;
         end
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (baud_tick !== 1'b1 && n < 800);
         check(16'(n), 16'(i < 3 ? DIV_9600 : i < 6 ? DIV_19200 : DIV_115200));
         check({15'h0, cfg_valid}, 16'h0001);
         e0 = execs;
         u_ssc_master_model.request(exp_tab[i], i * 7, granted);
         check({15'h0, granted}, 16'h0001);
         check({8'h00, reply_addr}, {8'h00, exp_tab[i]});
         u_ssc_master_model.request(ADDR_BROADCAST, 0, granted);
         @(posedge clk);
         #1;
         check({15'h0, granted | tx_grant}, 16'h0000);
         u_ssc_master_model.request(exp_tab[i] ^ 8'h04, 0, granted);
         check({15'h0, granted}, 16'h0000);
         check(16'(execs - e0), 16'h0001);
      end
      stop_test();
   end
endmodule
